// *** common/adcd_defines.vh ***
`ifndef ADCD_DEFINES_VH
`define ADCD_DEFINES_VH

// ----------------------------------------------------------------------------
// Word formats
// ----------------------------------------------------------------------------
`define ADCD_RES_W        16
`define ADCD_STAT_W       6
`define ADCD_FRAME_W      22
`define ADCD_CMD_W        8
`define ADCD_WR_W         16
`define ADCD_CNT_W        5
`define ADCD_CFG_W        8

// ----------------------------------------------------------------------------
// Command byte and configuration fields
// ----------------------------------------------------------------------------
`define ADCD_CMD_WRITE    8'h14
`define ADCD_CFG_RESET    8'h00
`define ADCD_CFG_FAST     1
`define ADCD_CFG_STAT     4

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define ADCD_CLK_PS       5000
`define ADCD_TCONV_PS     320000
`define ADCD_CONV_CYC     ((`ADCD_TCONV_PS + `ADCD_CLK_PS - 1) / `ADCD_CLK_PS)
`define ADCD_CONV_CW      7

// ----------------------------------------------------------------------------
// Buffer
// ----------------------------------------------------------------------------
`define ADCD_FIFO_DEPTH   8
`define ADCD_FIFO_AW      3

`endif

// *** rtl/adcd_fifo.v ***
`timescale 1ns/1ps
`default_nettype none

module adcd_fifo #(
  parameter WIDTH = 16,
  parameter DEPTH = 8,
  parameter AW    = 3
) (
  // Clock and reset
  input  wire             clk_i,
  input  wire             srst_i,
  // Fill side
  input  wire             in_valid_i,
  output reg              in_ready_o,
  input  wire [WIDTH-1:0] in_data_i,
  // Drain side
  output reg              out_valid_o,
  input  wire             out_ready_i,
  output reg  [WIDTH-1:0] out_data_o
);

  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wr_ptr;
  reg [AW-1:0]    rd_ptr;
  reg [AW:0]      count;
  reg [AW:0]      fill;
  reg [AW:0]      next_fill;
  wire            push;
  wire            pop;
  wire            leave;

  // Read data come from a register; the output stage is a one-word skid.
  // The fill count includes that stage, so the buffer never holds more than DEPTH words.
  assign push  = in_valid_i && in_ready_o;
  assign pop   = (count != {(AW+1){1'b0}}) && (!out_valid_o || out_ready_i);
  assign leave = out_valid_o && out_ready_i;

  always @* begin
    next_fill = fill;
    if (push && !leave)
      next_fill = fill + 1'b1;
    else if (leave && !push)
      next_fill = fill - 1'b1;
  end

  always @(posedge clk_i) begin
    if (srst_i) begin
      wr_ptr      <= {AW{1'b0}};
      rd_ptr      <= {AW{1'b0}};
      count       <= {(AW+1){1'b0}};
      out_valid_o <= 1'b0;
      out_data_o  <= {WIDTH{1'b0}};
      fill        <= {(AW+1){1'b0}};
      in_ready_o  <= 1'b1;
    end else begin
      fill        <= next_fill;
      in_ready_o  <= (next_fill != DEPTH[AW:0]);
      if (push) begin
        mem[wr_ptr] <= in_data_i;
        wr_ptr      <= wr_ptr + 1'b1;
      end
      if (pop) begin
        out_data_o <= mem[rd_ptr];
        rd_ptr     <= rd_ptr + 1'b1;
      end
      if (pop)
        out_valid_o <= 1'b1;
      else if (out_ready_i)
        out_valid_o <= 1'b0;
      if (push && !pop)
        count <= count + 1'b1;
      else if (pop && !push)
        count <= count - 1'b1;
    end
  end

endmodule

`default_nettype wire

// *** rtl/adcd_chain_port.v ***
// Summary of operation
// - Fast-readout is off after reset until software sets it.
// - Serial input and trigger both low, outside a write: serial output driven low.
// - Trigger rising edge starts a conversion; output held low meanwhile.
// - Conversion end presents result MSB on output, then acquisition begins.
// - Remaining result bits shift out, one per serial-clock falling edge.
// - Serial input captured on each rising edge, passing upstream data along.
// - Output data changes after each serial-clock falling edge and stays valid across the rising edge.
// - Register read-back is not offered while chained.
`timescale 1ns/1ps
`default_nettype none
`include "adcd_defines.vh"

module adcd_chain_port (
  // Clock and reset
  input  wire                     clk_i,
  input  wire                     srst_i,
  // Link pins
  input  wire                     conversion_trigger_i,
  input  wire                     sclk_i,
  input  wire                     sdi_i,
  output reg                      sdo_o,
  output reg                      sdo_oe_n_o,
  // Converter core
  input  wire                     res_valid_i,
  output wire                     res_ready_o,
  input  wire [`ADCD_RES_W-1:0]   res_data_i,
  input  wire [`ADCD_STAT_W-1:0]  status_i,
  // Status and configuration
  output reg                      converting_o,
  output reg                      no_result_o,
  output reg  [`ADCD_CFG_W-1:0]   cfg_o,
  output reg                      cfg_wr_o
);

  // ---------------------------------------------------------------------------
  // States
  // ---------------------------------------------------------------------------
  localparam ST_IDLE = 2'h0;
  localparam ST_CONV = 2'h1;
  localparam ST_READ = 2'h2;
  localparam ST_WRIT = 2'h3;

  reg  [1:0]                  state;
  reg  [1:0]                  next_state;
  reg  [2:0]                  trg_sync;
  reg  [2:0]                  clk_sync;
  reg  [1:0]                  sdi_sync;
  reg  [`ADCD_CONV_CW-1:0]    conv_cnt;
  reg  [`ADCD_FRAME_W-1:0]    shreg;
  reg  [`ADCD_WR_W-1:0]       wr_sh;
  reg  [`ADCD_CNT_W-1:0]      wr_cnt;
  wire                        trg;
  wire                        trg_rise;
  wire                        sck_rise;
  wire                        sck_fall;
  wire                        sdi;
  wire                        fifo_valid;
  wire [`ADCD_RES_W-1:0]      fifo_data;
  wire                        fifo_take;
  wire [`ADCD_RES_W-1:0]      head_data;

  function [`ADCD_FRAME_W-1:0] frame_word;
    input [`ADCD_RES_W-1:0]  res;
    input [`ADCD_STAT_W-1:0] stat;
    input                    with_stat;
    begin
      if (with_stat)
        frame_word = {res, stat};
      else
        frame_word = {res, {`ADCD_STAT_W{1'b0}}};
    end
  endfunction

  // With status bits off the frame is one result wide, so upstream bits enter
  // just below the result and surface after sixteen clocks.
  function [`ADCD_FRAME_W-1:0] shift_in;
    input [`ADCD_FRAME_W-1:0] cur;
    input                     bit_in;
    input                     with_stat;
    begin
      if (with_stat)
        shift_in = {cur[`ADCD_FRAME_W-2:0], bit_in};
      else
        shift_in = {cur[`ADCD_FRAME_W-2:`ADCD_STAT_W], bit_in, {`ADCD_STAT_W{1'b0}}};
    end
  endfunction

  // ---------------------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------------------
  // Only the second stage and beyond feed logic, so edge detection is clean.
  always @(posedge clk_i) begin
    if (srst_i) begin
      trg_sync <= 3'h0;
      clk_sync <= 3'h0;
      sdi_sync <= 2'h0;
    end else begin
      trg_sync <= {trg_sync[1:0], conversion_trigger_i};
      clk_sync <= {clk_sync[1:0], sclk_i};
      sdi_sync <= {sdi_sync[0], sdi_i};
    end
  end

  assign trg      = trg_sync[1];
  assign sdi      = sdi_sync[1];
  assign trg_rise = trg_sync[1] && !trg_sync[2];
  assign sck_rise = clk_sync[1] && !clk_sync[2];
  assign sck_fall = !clk_sync[1] && clk_sync[2];

  // ---------------------------------------------------------------------------
  // Result buffer
  // ---------------------------------------------------------------------------
  // Results queue here; a full buffer stalls the core, which is the trade for
  // never dropping a sample the host has not yet clocked out.
  assign fifo_take = (state == ST_CONV) && (conv_cnt == `ADCD_CONV_CYC - 1) && fifo_valid;

  adcd_fifo #(
    .WIDTH (`ADCD_RES_W),
    .DEPTH (`ADCD_FIFO_DEPTH),
    .AW    (`ADCD_FIFO_AW)
  ) u_fifo (
    .clk_i       (clk_i),
    .srst_i      (srst_i),
    .in_valid_i  (res_valid_i),
    .in_ready_o  (res_ready_o),
    .in_data_i   (res_data_i),
    .out_valid_o (fifo_valid),
    .out_ready_i (fifo_take),
    .out_data_o  (fifo_data)
  );

  // An empty buffer shifts out zeros rather than the last word a second time.
  assign head_data = fifo_valid ? fifo_data : {`ADCD_RES_W{1'b0}};

  // ---------------------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------------------
  always @* begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (trg_rise)
          next_state = ST_CONV;
        else if (!trg && sck_rise)
          next_state = ST_WRIT;
      end
      ST_CONV: begin
        if (!trg)
          next_state = ST_IDLE;
        else if (conv_cnt == `ADCD_CONV_CYC - 1)
          next_state = ST_READ;
      end
      ST_READ: begin
        if (!trg)
          next_state = ST_IDLE;
      end
      ST_WRIT: begin
        if (trg)
          next_state = ST_CONV;
      end
      default: next_state = ST_IDLE;
    endcase
  end

  always @(posedge clk_i) begin
    if (srst_i) begin
      state        <= ST_IDLE;
      conv_cnt     <= {`ADCD_CONV_CW{1'b0}};
      shreg        <= {`ADCD_FRAME_W{1'b0}};
      wr_sh        <= {`ADCD_WR_W{1'b0}};
      wr_cnt       <= {`ADCD_CNT_W{1'b0}};
      sdo_o        <= 1'b0;
      sdo_oe_n_o   <= 1'b0;
      converting_o <= 1'b0;
      no_result_o  <= 1'b0;
      cfg_o        <= `ADCD_CFG_RESET;
      cfg_wr_o     <= 1'b0;
    end else begin
      state      <= next_state;
      cfg_wr_o   <= 1'b0;
      sdo_oe_n_o <= 1'b0;
      converting_o <= (next_state == ST_CONV);
      if (state == ST_CONV)
        conv_cnt <= conv_cnt + 1'b1;
      else
        conv_cnt <= {`ADCD_CONV_CW{1'b0}};
      case (state)
        ST_IDLE: begin
          sdo_o  <= 1'b0;
          wr_cnt <= {`ADCD_CNT_W{1'b0}};
          if (!trg && sck_rise) begin
            wr_sh  <= {wr_sh[`ADCD_WR_W-2:0], sdi};
            wr_cnt <= 5'h01;
          end
        end
        ST_CONV: begin
          sdo_o <= 1'b0;
          if (conv_cnt == `ADCD_CONV_CYC - 1) begin
            shreg       <= frame_word(head_data, status_i, cfg_o[`ADCD_CFG_STAT]);
            sdo_o       <= head_data[`ADCD_RES_W-1];
            no_result_o <= !fifo_valid;
          end
        end
        ST_READ: begin
          if (sck_rise)
            shreg <= shift_in(shreg, sdi, cfg_o[`ADCD_CFG_STAT]);
          if (sck_fall)
            sdo_o <= shreg[`ADCD_FRAME_W-1];
        end
        ST_WRIT: begin
          // Write path: each falling edge loads the oldest shifted-in bit, wr_sh MSB, onto the output.
          // The count saturates, so a long chain write cannot wrap it.
          if (sck_rise) begin
            wr_sh  <= {wr_sh[`ADCD_WR_W-2:0], sdi};
            if (wr_cnt != `ADCD_WR_W)
              wr_cnt <= wr_cnt + 1'b1;
          end
          if (sck_fall)
            sdo_o <= wr_sh[`ADCD_WR_W-1];
          if (trg) begin
            sdo_o <= 1'b0;
            if (wr_cnt >= `ADCD_WR_W &&
                wr_sh[`ADCD_WR_W-1:`ADCD_CFG_W] == `ADCD_CMD_WRITE) begin
              cfg_o    <= wr_sh[`ADCD_CFG_W-1:0];
              cfg_wr_o <= 1'b1;
            end
          end
        end
        default: sdo_o <= 1'b0;
      endcase
    end
  end

endmodule

`default_nettype wire

// *** bench/adcd_chain_port_sva.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "adcd_defines.vh"
module adcd_chain_port_sva (
  input wire logic                   clk_i,
  input wire logic                   srst_i,
  input wire logic                   conversion_trigger_i,
  input wire logic                   sclk_i,
  input wire logic                   sdi_i,
  input wire logic                   sdo_o,
  input wire logic                   sdo_oe_n_o,
  input wire logic                   converting_o,
  input wire logic [`ADCD_CFG_W-1:0] cfg_o,
  input wire logic                   cfg_wr_o
);
  // ----
  // Conversion length is counted here, since it is longer than a repetition can hold.
  // ----
  logic [7:0] conv_cnt;
  always_ff @(posedge clk_i) begin
    conv_cnt <= (srst_i || !converting_o) ? 8'h00 : conv_cnt + 8'h01;
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (srst_i);
  sequence start_s;
    $rose(conversion_trigger_i) && !sdi_i && !sclk_i && !converting_o;
  endsequence
  sequence sclk_high_s;
    sclk_i [*6];
  endsequence
  oe_low_a: assert property (sdo_oe_n_o == 1'b0) else $error("sdo released");
  conv_start_a: assert property (start_s |-> ##[1:5] converting_o)
    else $error("no conversion after trigger");
  conv_quiet_a: assert property (converting_o |-> !sdo_o) else $error("sdo high in conversion");
  conv_len_a: assert property ($fell(converting_o) && conversion_trigger_i
    |-> conv_cnt == `ADCD_CONV_CYC) else $error("conversion length wrong");
  cfg_pulse_a: assert property (cfg_wr_o |=> !cfg_wr_o) else $error("long write pulse");
  cfg_hold_a: assert property ($changed(cfg_o) |-> cfg_wr_o) else $error("stray cfg change");
  sdo_hold_a: assert property (sclk_high_s ##0 conversion_trigger_i |-> $stable(sdo_o))
    else $error("sdo moved while sclk high");
  rst_clear_a: assert property ($fell(srst_i) |-> cfg_o == `ADCD_CFG_RESET && !sdo_o)
    else $error("reset state wrong");
endmodule
bind adcd_chain_port adcd_chain_port_sva u_sva (.clk_i(clk_i), .srst_i(srst_i),
  .conversion_trigger_i(conversion_trigger_i), .sclk_i(sclk_i), .sdi_i(sdi_i),
  .sdo_o(sdo_o), .sdo_oe_n_o(sdo_oe_n_o), .converting_o(converting_o), .cfg_o(cfg_o),
  .cfg_wr_o(cfg_wr_o));
`default_nettype wire

// *** bench/adcd_host_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module adcd_host_model (
  input  wire logic clk_i,
  input  wire logic sdo_i,
  output var  logic conversion_trigger_o,
  output var  logic sclk_o,
  output var  logic sdi_o
);
  // ----
  // Serial clock of 125 ns, made only inside frames and still between them.
  // ----
  initial begin
    conversion_trigger_o = 1'b0;
    sclk_o = 1'b0;
    sdi_o = 1'b0;
  end
  task automatic bit_cycle(input logic d, output logic q);
    sdi_o <= d;
    repeat (12) @(posedge clk_i);
    q = sdo_i;
    sclk_o <= 1'b1;
    repeat (13) @(posedge clk_i);
    sclk_o <= 1'b0;
  endtask
  task automatic read(input int n, input logic [31:0] pat, output logic [31:0] rx);
    logic q;
    rx = 32'h0;
    repeat (4) @(posedge clk_i);
    conversion_trigger_o <= 1'b1;
    repeat (75) @(posedge clk_i);
    for (int i = 0; i < n; i++) begin
      bit_cycle(pat[31-i], q);
      rx = {rx[30:0], q};
    end
    repeat (12) @(posedge clk_i);
    conversion_trigger_o <= 1'b0;
    sdi_o <= 1'b0;
  endtask
  task automatic write(input int n, input logic [31:0] w, output logic [31:0] rx);
    logic q;
    rx = 32'h0;
    @(posedge clk_i);
    for (int i = 0; i < n; i++) begin
      bit_cycle(w[n-1-i], q);
      rx = {rx[30:0], q};
    end
    sdi_o <= 1'b0;
    repeat (12) @(posedge clk_i);
    conversion_trigger_o <= 1'b1;
    repeat (75) @(posedge clk_i);
    conversion_trigger_o <= 1'b0;
  endtask
endmodule
`default_nettype wire

// *** bench/tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "adcd_defines.vh"
module tb_top;
  logic        clk_i, srst_i, trig, sclk, sdi, sdo, oe_n, res_valid, res_ready;
  logic        converting, no_result, cfg_wr;
  logic [15:0] res_data;
  logic [5:0]  status;
  logic [7:0]  cfg;
  logic [31:0] rx;
  int          fail_count = 0;
  int          total_checks = 0;
  typedef struct {logic [7:0] c; logic [15:0] r; logic [5:0] s; int n; logic [31:0] p, e;} adcd_row_t;
  adcd_row_t   rows [3] = '{'{8'h00, 16'hA5C3, 6'h00, 16, 32'h0, 32'h0000A5C3},
                            '{8'h10, 16'h1234, 6'h2A, 22, 32'h0, {10'h0, 16'h1234, 6'h2A}},
                            '{8'h00, 16'h8001, 6'h00, 32, 32'h5A0F0000, 32'h80015A0F}};
  adcd_chain_port DUT (.clk_i(clk_i), .srst_i(srst_i), .conversion_trigger_i(trig),
    .sclk_i(sclk), .sdi_i(sdi), .sdo_o(sdo), .sdo_oe_n_o(oe_n), .res_valid_i(res_valid),
    .res_ready_o(res_ready), .res_data_i(res_data), .status_i(status),
    .converting_o(converting), .no_result_o(no_result), .cfg_o(cfg), .cfg_wr_o(cfg_wr));
  adcd_host_model u_host (.clk_i(clk_i), .sdo_i(sdo), .conversion_trigger_o(trig),
    .sclk_o(sclk), .sdi_o(sdi));
  // ----
  // Shared tasks.
  // ----
  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic push(input logic [15:0] d);
    @(posedge clk_i);
    res_data <= d;
    res_valid <= 1'b1;
    do @(posedge clk_i); while (res_ready !== 1'b1);
    res_valid <= 1'b0;
  endtask
  task automatic summarize();
    $display("checks=%0d mismatches=%0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    repeat (40000) @(posedge clk_i);
    fail_count++;
    summarize();
  end
  initial begin
    srst_i = 1'b1;
    res_valid = 1'b0;
    res_data = 16'h0000;
    status = 6'h00;
    repeat (3) @(posedge clk_i);
    srst_i <= 1'b0;
    repeat (4) @(negedge clk_i);
    check({20'h0, cfg, sdo, oe_n, converting, res_ready}, 32'h1);
    $display("reset test done");
    foreach (rows[i]) begin
      u_host.write(16, {16'h0, `ADCD_CMD_WRITE, rows[i].c}, rx);
      @(negedge clk_i);
      check({24'h0, cfg}, {24'h0, rows[i].c});
      push(rows[i].r);
      status <= rows[i].s;
      u_host.read(rows[i].n, rows[i].p, rx);
      check(rx, rows[i].e);
      repeat (6) @(negedge clk_i);
      check({31'h0, sdo}, 32'h0);
      $display("row %0d done", i);
    end
    // A leading byte must pass through, as it would to a further device.
    u_host.write(24, {8'h0, 8'hC3, `ADCD_CMD_WRITE, 8'h10}, rx);
    check({24'h0, cfg}, 32'h10);
    check({24'h0, rx[7:0]}, 32'hC3);
    u_host.write(16, {16'h0, 8'h15, 8'hFF}, rx);
    check({24'h0, cfg}, 32'h10);
    @(posedge clk_i);
    srst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    srst_i <= 1'b0;
    repeat (4) @(negedge clk_i);
    check({20'h0, cfg, sdo, oe_n, converting, res_ready}, 32'h1);
    $display("mid-run reset test done");
    u_host.write(16, {16'h0, `ADCD_CMD_WRITE, 8'h12}, rx);
    check({24'h0, cfg}, 32'h12);
    u_host.write(16, {16'h0, `ADCD_CMD_WRITE, 8'h00}, rx);
    check({24'h0, cfg}, 32'h0);
    $display("write tests done");
    repeat (4) @(posedge clk_i);
    u_host.conversion_trigger_o <= 1'b1;
    repeat (20) @(posedge clk_i);
    u_host.conversion_trigger_o <= 1'b0;
    repeat (8) @(negedge clk_i);
    check({30'h0, converting, sdo}, 32'h0);
    $display("abort test done");
    for (int k = 0; k < 8; k++) push(16'h1000 + 16'(k));
    @(negedge clk_i);
    check({31'h0, res_ready}, 32'h0);
    for (int k = 0; k < 9; k++) begin
      u_host.read(16, 32'h0, rx);
      check(rx, (k < 8) ? 32'h1000 + 32'(k) : 32'h0);
    end
    check({31'h0, no_result}, 32'h1);
    $display("buffer test done");
    summarize();
  end
endmodule
`default_nettype wire
